//--- inc/cos_pkg.sv
// Notes on behaviour
// - With tri-level at a logic level, the low selects pick CPU 66/100/200/133 MHz.
// - Tri-level high makes the shared pin a 66 MHz input for the buffered outputs, PCI at half.
// - Tri-level middle with 00 floats every output; with 01 it runs the divided test clock.
// - A middle tri-level seen at power-up is recorded as zero in the internal state register.
// - All selects are frozen while the qualifier is low, and the system holds them stable first.
// - Power-down low stops every output buffer and all logic except the serial interface and the select latches.
// - PCI stop low parks the seven stoppable PCI outputs low, and free-running ones whose configuration bit is clear.
// - Three configuration bits make each free-running PCI output free running or stoppable.
// - CPU stop low parks the true CPU outputs high and the complement outputs low.
// - The selectable output runs at 48 MHz when its configuration bit is 1, else 66 MHz.
// - PCI outputs follow the 66 MHz source and are derived by dividing it by two.
// - The reference output is a buffered copy of the oscillator input.
// - USB and DOT outputs run at a fixed 48 MHz in all normal settings.
// - The fixed 66 MHz output runs continuously for every select except the test mode, where it runs the /4 test clock.
// - The serial data line is an input, driven only as an open-drain low.
// - The reported PCI stop state is the AND of the stop pin and the internal stop bit.
package cos_pkg;

    localparam int N_CPU  = 3;
    localparam int N_PCI  = 7;
    localparam int N_FREE_RUNNING_PCI_CLK = 3;
    localparam int N_B66  = 3;

    // Low frequency select codes for the CPU pair, and for the middle tri-level modes
    localparam logic [1:0] CPU_SEL_66  = 2'h0;
    localparam logic [1:0] CPU_SEL_100 = 2'h1;
    localparam logic [1:0] CPU_SEL_200 = 2'h2;
    localparam logic [1:0] CPU_SEL_133 = 2'h3;
    localparam logic [1:0] MID_SEL_HIZ  = 2'h0;
    localparam logic [1:0] MID_SEL_TEST = 2'h1;

    // Reset values
    localparam logic [1:0] RST_LOW_SEL  = 2'h0;
    localparam logic       RST_MULT     = 1'h1;
    localparam logic [2:0] RST_TEST_CNT = 3'h0;
    localparam logic       RST_CLK      = 1'h0;

    // Test divider taps: /4 toggles on bit 0 set, /8 on bits 1:0 set
    localparam logic [1:0] TEST_DIV8_MASK = 2'h3;

    typedef enum logic [1:0] {
        TRI_LOW,
        TRI_MID,
        TRI_HIGH
    } cos_tri_e;

    // Half-period toggle strobes from the synthesis loop, one core cycle each
    typedef struct packed {
        logic cpu66;
        logic cpu100;
        logic cpu133;
        logic cpu200;
        logic m66;
        logic m48;
    } cos_tick_s;

    // Serial configuration bits held by the management interface
    typedef struct packed {
        logic       sel_48;
        logic [2:0] free_running_pci_clk_free;
        logic       pci_stop_bit_n;
    } cos_cfg_s;

endpackage

//--- hw/cos_gate.sv
`timescale 1ns/1ps

// One clock output: toggles on its strobe, parks glitch-free at PARK
module cos_gate #(
    parameter logic PARK = 1'h0,
    parameter logic INIT = 1'h0
) (
    // Clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_sys_rst,
    // Control
    input  wire logic i_hold,
    input  wire logic i_tick,
    input  wire logic i_stop,
    // Output
    output logic      o_clk_r
);

    logic run;
    logic clk_nxt;

    assign run     = (o_clk_r == PARK) ? ~i_stop : 1'b1;
    assign clk_nxt = (i_tick && run && !i_hold) ? ~o_clk_r : o_clk_r;

    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
            o_clk_r <= INIT;
        else
            o_clk_r <= clk_nxt;
    end

endmodule

//--- hw/cos_top.sv
`timescale 1ns/1ps

module cos_top (
    // Clock and reset
    input  wire logic               i_core_clk,
    input  wire logic               i_sys_rst,
    // Frequency selects and qualifiers
    input  cos_pkg::cos_tri_e       i_tri_level_freq_select,
    input  wire logic [1:0]         i_low_freq_select,
    input  wire logic               i_current_multiplier_select,
    input  wire logic               i_select_latch_qualifier_n,
    input  wire logic               i_power_down_n,
    input  wire logic               i_cpu_stop_n,
    input  wire logic               i_pci_stop_n,
    // Clock sources
    input  wire logic               i_oscillator_input,
    input  wire logic               i_shared_66mhz_in,
    input  cos_pkg::cos_tick_s      i_tick,
    // Serial configuration and data line
    input  cos_pkg::cos_cfg_s       i_cfg,
    input  wire logic               i_serial_data_line,
    input  wire logic               i_serial_drive_low,
    output logic                    o_serial_data_line,
    output logic                    o_serial_data_line_oe,
    output logic                    o_serial_data_in_r,
    // Status
    output logic                    o_pci_stop_status_r,
    output logic                    o_tri_state_latched_r,
    output logic [1:0]              o_low_sel_latched_r,
    output logic                    o_current_multiplier_r,
    // Clock outputs
    output logic [2:0]              o_cpu_true_out,
    output logic [2:0]              o_cpu_complement_out,
    output logic [6:0]              o_pci_clk,
    output logic [2:0]              o_free_running_pci_clk,
    output logic [2:0]              o_buffered_66mhz_outputs,
    output logic                    o_fixed_66mhz_out,
    output logic                    o_selectable_66_48_out,
    output logic                    o_shared_66mhz_in_out,
    output logic                    o_shared_66mhz_oe_r,
    output logic                    o_usb_48mhz_out,
    output logic                    o_dot_48mhz_out,
    output logic                    o_ref_clk_out,
    output logic                    o_clk_oe_r
);

    ////////////////////////////////////////////////////////////////////////////
    // Select latching

    cos_pkg::cos_tri_e tri_r;
    cos_pkg::cos_tri_e tri_nxt;
    logic [1:0]        low_nxt;
    logic              mult_nxt;

    assign tri_nxt  = i_select_latch_qualifier_n ? i_tri_level_freq_select : tri_r;
    assign low_nxt  = i_select_latch_qualifier_n ? i_low_freq_select : o_low_sel_latched_r;
    assign mult_nxt = i_select_latch_qualifier_n ? i_current_multiplier_select
                                                 : o_current_multiplier_r;

    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            tri_r                  <= cos_pkg::TRI_LOW;
            o_low_sel_latched_r    <= cos_pkg::RST_LOW_SEL;
            o_current_multiplier_r <= cos_pkg::RST_MULT;
            o_tri_state_latched_r  <= 1'b0;
        end
        else
        begin
            tri_r                  <= tri_nxt;
            o_low_sel_latched_r    <= low_nxt;
            o_current_multiplier_r <= mult_nxt;
            o_tri_state_latched_r  <= (tri_nxt == cos_pkg::TRI_HIGH);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode

    logic run_en;
    logic hiz;
    logic test;
    logic in66_mode;

    assign hiz       = (tri_r == cos_pkg::TRI_MID)
                       && (o_low_sel_latched_r == cos_pkg::MID_SEL_HIZ);
    assign test      = (tri_r == cos_pkg::TRI_MID)
                       && (o_low_sel_latched_r == cos_pkg::MID_SEL_TEST);
    assign in66_mode = (tri_r == cos_pkg::TRI_HIGH);
    // power-down freezes every divider and gate
    assign run_en    = i_power_down_n;

    ////////////////////////////////////////////////////////////////////////////
    // Test clock dividers and 66 MHz input edges

    logic       osc_r;
    logic       in66_r;
    logic [2:0] tcnt_r;
    logic       osc_rise;
    logic       in66_edge;

    assign osc_rise  = i_oscillator_input && !osc_r;
    assign in66_edge = i_shared_66mhz_in != in66_r;

    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            osc_r  <= cos_pkg::RST_CLK;
            in66_r <= cos_pkg::RST_CLK;
            tcnt_r <= cos_pkg::RST_TEST_CNT;
        end
        else
        begin
            osc_r  <= i_oscillator_input;
            in66_r <= i_shared_66mhz_in;
            tcnt_r <= (osc_rise && run_en) ? tcnt_r + 3'h1 : tcnt_r;
        end
    end

    logic t_div2;
    logic t_div4;
    logic t_div8;

    assign t_div2 = osc_rise;
    assign t_div4 = osc_rise && tcnt_r[0];
    assign t_div8 = osc_rise && (tcnt_r[1:0] == cos_pkg::TEST_DIV8_MASK);

    ////////////////////////////////////////////////////////////////////////////
    // Strobe selection

    logic cpu_tick;
    logic cpu_norm;
    logic src66;
    logic fix66;
    logic buf66;
    logic pci_tick;
    logic sel_tick;
    logic usb_tick;
    logic src66_r;

    assign cpu_norm = (o_low_sel_latched_r == cos_pkg::CPU_SEL_66)  ? i_tick.cpu66  :
                      (o_low_sel_latched_r == cos_pkg::CPU_SEL_100) ? i_tick.cpu100 :
                      (o_low_sel_latched_r == cos_pkg::CPU_SEL_200) ? i_tick.cpu200 :
                                                                     i_tick.cpu133;
    assign cpu_tick = test ? t_div2 : cpu_norm;
    assign fix66    = test ? t_div4 : i_tick.m66;
    assign src66    = in66_mode ? in66_edge : i_tick.m66;
    assign buf66    = test ? t_div4 : src66;
    // PCI is the 66 source divided by two
    assign pci_tick = test ? t_div8 : (src66 && !src66_r);
    // 48 or 66 by configuration bit
    assign sel_tick = test ? t_div4 : (i_cfg.sel_48 ? i_tick.m48 : i_tick.m66);
    assign usb_tick = test ? t_div2 : i_tick.m48;

    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
            src66_r <= cos_pkg::RST_CLK;
        else if (src66 && run_en)
            src66_r <= ~src66_r;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stop requests

    logic       cpu_stop;
    logic       pci_stop;
    logic [2:0] free_running_pci_clk_stop;

    assign cpu_stop  = !i_cpu_stop_n;
    assign pci_stop  = !(i_pci_stop_n && i_cfg.pci_stop_bit_n);
    assign free_running_pci_clk_stop = {3{pci_stop}} & ~i_cfg.free_running_pci_clk_free;

    ////////////////////////////////////////////////////////////////////////////
    // Output gates

    genvar g;
    generate
        for (g = 0; g < cos_pkg::N_CPU; g++)
        begin : g_cpu
            cos_gate #(.PARK(1'b1), .INIT(1'b1)) u_true (
                .i_core_clk (i_core_clk),
                .i_sys_rst  (i_sys_rst),
                .i_hold     (!run_en),
                .i_tick     (cpu_tick),
                .i_stop     (cpu_stop),
                .o_clk_r    (o_cpu_true_out[g])
            );
            cos_gate #(.PARK(1'b0), .INIT(1'b0)) u_comp (
                .i_core_clk (i_core_clk),
                .i_sys_rst  (i_sys_rst),
                .i_hold     (!run_en),
                .i_tick     (cpu_tick),
                .i_stop     (cpu_stop),
                .o_clk_r    (o_cpu_complement_out[g])
            );
        end
        for (g = 0; g < cos_pkg::N_PCI; g++)
        begin : g_pci
            cos_gate #(.PARK(1'b0), .INIT(1'b0)) u_pci (
                .i_core_clk (i_core_clk),
                .i_sys_rst  (i_sys_rst),
                .i_hold     (!run_en),
                .i_tick     (pci_tick),
                .i_stop     (pci_stop),
                .o_clk_r    (o_pci_clk[g])
            );
        end
        for (g = 0; g < cos_pkg::N_FREE_RUNNING_PCI_CLK; g++)
        begin : g_free_running_pci_clk
            cos_gate #(.PARK(1'b0), .INIT(1'b0)) u_free_running_pci_clk (
                .i_core_clk (i_core_clk),
                .i_sys_rst  (i_sys_rst),
                .i_hold     (!run_en),
                .i_tick     (pci_tick),
                .i_stop     (free_running_pci_clk_stop[g]),
                .o_clk_r    (o_free_running_pci_clk[g])
            );
        end
        for (g = 0; g < cos_pkg::N_B66; g++)
        begin : g_b66
            cos_gate #(.PARK(1'b0), .INIT(1'b0)) u_b66 (
                .i_core_clk (i_core_clk),
                .i_sys_rst  (i_sys_rst),
                .i_hold     (!run_en),
                .i_tick     (buf66),
                .i_stop     (1'b0),
                .o_clk_r    (o_buffered_66mhz_outputs[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Fixed outputs and pin enables

    logic ref_nxt;

    assign ref_nxt = run_en ? i_oscillator_input : o_ref_clk_out;

    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            o_fixed_66mhz_out      <= cos_pkg::RST_CLK;
            o_selectable_66_48_out <= cos_pkg::RST_CLK;
            o_shared_66mhz_in_out  <= cos_pkg::RST_CLK;
            o_usb_48mhz_out        <= cos_pkg::RST_CLK;
            o_dot_48mhz_out        <= cos_pkg::RST_CLK;
            o_ref_clk_out          <= cos_pkg::RST_CLK;
            o_clk_oe_r             <= 1'b0;
            o_shared_66mhz_oe_r    <= 1'b0;
        end
        else
        begin
            o_fixed_66mhz_out      <= (fix66 && run_en) ? ~o_fixed_66mhz_out : o_fixed_66mhz_out;
            o_selectable_66_48_out <= (sel_tick && run_en) ? ~o_selectable_66_48_out
                                                           : o_selectable_66_48_out;
            o_shared_66mhz_in_out  <= (fix66 && run_en) ? ~o_shared_66mhz_in_out
                                                        : o_shared_66mhz_in_out;
            o_usb_48mhz_out        <= (usb_tick && run_en) ? ~o_usb_48mhz_out : o_usb_48mhz_out;
            o_dot_48mhz_out        <= (usb_tick && run_en) ? ~o_dot_48mhz_out : o_dot_48mhz_out;
            o_ref_clk_out          <= ref_nxt;
            // all outputs float in the high-impedance mode
            o_clk_oe_r             <= run_en && !hiz;
            // shared pin is an input when tri-level high
            o_shared_66mhz_oe_r    <= run_en && !hiz && !in66_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial line and status; kept alive through power-down

    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            o_serial_data_line    <= 1'b0;
            o_serial_data_line_oe <= 1'b0;
            o_serial_data_in_r    <= 1'b1;
            o_pci_stop_status_r   <= 1'b1;
        end
        else
        begin
            o_serial_data_line    <= 1'b0;
            o_serial_data_line_oe <= i_serial_drive_low;
            o_serial_data_in_r    <= i_serial_data_line;
            o_pci_stop_status_r   <= i_pci_stop_n && i_cfg.pci_stop_bit_n;
        end
    end

endmodule

//--- testbench/cos_props.sv
`timescale 1ns/1ps

module cos_props (
    // Clock and reset
    input  wire logic         i_core_clk,
    input  wire logic         i_sys_rst,
    // Watched inputs
    input  cos_pkg::cos_tri_e i_tri_level_freq_select,
    input  wire logic [1:0]   i_low_freq_select,
    input  wire logic         i_select_latch_qualifier_n,
    input  wire logic         i_power_down_n,
    input  wire logic         i_cpu_stop_n,
    input  wire logic         i_pci_stop_n,
    input  wire logic         i_oscillator_input,
    input  cos_pkg::cos_cfg_s i_cfg,
    input  wire logic         i_serial_drive_low,
    // Watched outputs
    input  wire logic         o_serial_data_line,
    input  wire logic         o_serial_data_line_oe,
    input  wire logic         o_pci_stop_status_r,
    input  wire logic         o_tri_state_latched_r,
    input  wire logic [1:0]   o_low_sel_latched_r,
    input  wire logic [2:0]   o_cpu_true_out,
    input  wire logic [2:0]   o_cpu_complement_out,
    input  wire logic [6:0]   o_pci_clk,
    input  wire logic         o_ref_clk_out,
    input  wire logic         o_clk_oe_r
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    ////////////////////////////////////////////////////////////////////////////////
    serial_drain_a:
    assert property (!$past(i_sys_rst) |-> !o_serial_data_line
        && o_serial_data_line_oe == $past(i_serial_drive_low))
        else $error("serial line drive does not follow the request");
    pci_status_a:
    assert property (!$past(i_sys_rst) |-> o_pci_stop_status_r
        == $past(i_pci_stop_n & i_cfg.pci_stop_bit_n)) else $error("pci stop status wrong");
    latch_track_a:
    assert property ($past(i_select_latch_qualifier_n) && !$past(i_sys_rst)
        |-> o_low_sel_latched_r == $past(i_low_freq_select)) else $error("selects not tracked");
    latch_hold_a:
    assert property (!$past(i_select_latch_qualifier_n) && !$past(i_sys_rst)
        |-> $stable(o_low_sel_latched_r)) else $error("selects moved while frozen");
    tri_mid_a:
    assert property ($past(i_select_latch_qualifier_n) && !$past(i_sys_rst) |->
        o_tri_state_latched_r == ($past(i_tri_level_freq_select) == cos_pkg::TRI_HIGH))
        else $error("tri-level state bit wrong");
    cpu_pair_a:
    assert property (o_cpu_complement_out == ~o_cpu_true_out)
        else $error("cpu pair not complementary");
    cpu_park_a:
    assert property (!i_cpu_stop_n && o_cpu_true_out == 3'h7 |=> o_cpu_true_out == 3'h7)
        else $error("stopped cpu clock left its high park");
    pci_park_a:
    assert property (!(i_pci_stop_n & i_cfg.pci_stop_bit_n) && o_pci_clk == 7'h00
        |=> o_pci_clk == 7'h00) else $error("stopped pci clock left its low park");
    pd_oe_a:
    assert property (!i_power_down_n |=> !o_clk_oe_r) else $error("outputs driven in power-down");
    ref_copy_a:
    assert property (!$past(i_sys_rst) && $past(i_power_down_n) && o_clk_oe_r
        |-> o_ref_clk_out == $past(i_oscillator_input)) else $error("ref is not the oscillator");

    cover property (!i_cpu_stop_n && o_cpu_true_out == 3'h7);
    cover property (i_power_down_n && !o_clk_oe_r);
    cover property (o_serial_data_line_oe);
endmodule

bind cos_top cos_props i_props (
    .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
    .i_tri_level_freq_select(i_tri_level_freq_select), .i_low_freq_select(i_low_freq_select),
    .i_select_latch_qualifier_n(i_select_latch_qualifier_n), .i_power_down_n(i_power_down_n),
    .i_cpu_stop_n(i_cpu_stop_n), .i_pci_stop_n(i_pci_stop_n),
    .i_oscillator_input(i_oscillator_input), .i_cfg(i_cfg),
    .i_serial_drive_low(i_serial_drive_low), .o_serial_data_line(o_serial_data_line),
    .o_serial_data_line_oe(o_serial_data_line_oe), .o_pci_stop_status_r(o_pci_stop_status_r),
    .o_tri_state_latched_r(o_tri_state_latched_r), .o_low_sel_latched_r(o_low_sel_latched_r),
    .o_cpu_true_out(o_cpu_true_out), .o_cpu_complement_out(o_cpu_complement_out),
    .o_pci_clk(o_pci_clk), .o_ref_clk_out(o_ref_clk_out), .o_clk_oe_r(o_clk_oe_r)
);

//--- testbench/cos_rx_model.sv
`timescale 1ns/1ps

// Clock receivers: count level changes on watched outputs
module cos_rx_model (
    // Clock and counter clear
    input  wire logic       i_core_clk,
    input  wire logic       i_clr,
    // Watched clocks
    input  wire logic [9:0] i_clk_in,
    // Serial line
    input  wire logic       i_sda_out,
    input  wire logic       i_sda_oe,
    output logic            o_sda_line,
    // Toggle counts
    output int              o_cnt [10]
);
    logic [9:0] last_r;

    // open-drain line
    // Released line is pulled up, never left at the last driven level
    assign o_sda_line = i_sda_oe ? i_sda_out : 1'h1;

    always_ff @(posedge i_core_clk)
    begin
        last_r <= i_clk_in;
        for (int k = 0; k < 10; k++)
            o_cnt[k] <= i_clr ? 0 : o_cnt[k] + int'(i_clk_in[k] != last_r[k]);
    end
endmodule

//--- testbench/test_clock_output_select_and_gating.sv
`timescale 1ns/1ps

module test_clock_output_select_and_gating;
    logic i_core_clk, i_sys_rst, i_current_multiplier_select, i_select_latch_qualifier_n;
    logic i_power_down_n, i_cpu_stop_n, i_pci_stop_n, i_oscillator_input, i_shared_66mhz_in;
    logic i_serial_data_line, i_serial_drive_low, o_serial_data_line, o_serial_data_line_oe;
    logic o_serial_data_in_r, o_pci_stop_status_r, o_tri_state_latched_r, o_current_multiplier_r;
    logic o_fixed_66mhz_out, o_selectable_66_48_out, o_shared_66mhz_in_out, o_shared_66mhz_oe_r;
    logic o_usb_48mhz_out, o_dot_48mhz_out, o_ref_clk_out, o_clk_oe_r, clr;
    logic [1:0] i_low_freq_select, o_low_sel_latched_r;
    logic [2:0] o_cpu_true_out, o_cpu_complement_out, o_free_running_pci_clk;
    logic [2:0] o_buffered_66mhz_outputs;
    logic [6:0] o_pci_clk;
    cos_pkg::cos_tri_e  i_tri_level_freq_select;
    cos_pkg::cos_tick_s i_tick;
    cos_pkg::cos_cfg_s  i_cfg;
    int cnt [10];
    int cyc, failures, n_checks;

    cos_top i_dut (.*);
    cos_rx_model i_rx (.i_core_clk(i_core_clk), .i_clr(clr), .i_sda_out(o_serial_data_line),
        .i_clk_in({o_fixed_66mhz_out, o_ref_clk_out, o_usb_48mhz_out, o_selectable_66_48_out,
        o_buffered_66mhz_outputs[0], o_free_running_pci_clk, o_pci_clk[0], o_cpu_true_out[0]}),
        .i_sda_oe(o_serial_data_line_oe), .o_sda_line(i_serial_data_line), .o_cnt(cnt));

    initial
    begin
        i_core_clk = 1'h0;
        forever #2 i_core_clk = ~i_core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Strobe periods 6/4/3/2 cycles pick cpu 66/100/133/200, m66 every 4, m48 every 5
    always @(posedge i_core_clk)
    begin
        #1;
        cyc = cyc + 1;
        i_tick = '{cyc % 6 == 0, cyc % 4 == 0, cyc % 3 == 0, cyc % 2 == 0,
                   cyc % 4 == 0, cyc % 5 == 0};
        if (cyc % 3 == 0)
            i_oscillator_input = ~i_oscillator_input;
        if (cyc % 5 == 0)
            i_shared_66mhz_in = ~i_shared_66mhz_in;
    end

    task automatic chk(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'h1)
        begin
            failures++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask

    function automatic logic near(input int n, input int e);
        return n >= e - 1 && n <= e + 1;
    endfunction

    task automatic waitc(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask

    // Count toggles over n cycles
    task automatic win(input int n);
        clr = 1'h1;
        waitc(1);
        clr = 1'h0;
        waitc(n);
    endtask

    task automatic set_mode(input cos_pkg::cos_tri_e t, input logic [1:0] s);
        i_tri_level_freq_select = t;
        i_low_freq_select = s;
        waitc(6);
    endtask

    task automatic t_low();
        int e [4] = '{20, 30, 60, 40};
        for (int s = 0; s < 4; s++)
        begin
            set_mode(cos_pkg::TRI_LOW, 2'(s));
            win(120);
            chk(near(cnt[0], e[s]), "cpu rate");
        end
        chk(o_shared_66mhz_oe_r === 1'h1 && near(cnt[5], 30), "66 outputs");
        chk(near(cnt[1], 15) && near(cnt[2], 15), "pci half of 66");
        chk(near(cnt[8], 40), "ref copy");
        chk(near(cnt[7], 24), "usb rate");
        chk(near(cnt[9], 30), "fixed 66");
        chk(o_cpu_true_out === {3{o_cpu_true_out[0]}}, "cpu copies");
        chk(o_pci_clk === {7{o_pci_clk[0]}}, "pci copies");
        chk(o_buffered_66mhz_outputs === {3{o_buffered_66mhz_outputs[0]}}, "66 copies");
        chk(o_shared_66mhz_in_out === o_fixed_66mhz_out, "shared 66 out");
        chk(o_dot_48mhz_out === o_usb_48mhz_out, "dot rate");
    endtask

    task automatic t_high();
        set_mode(cos_pkg::TRI_HIGH, 2'h0);
        win(120);
        chk(o_shared_66mhz_oe_r === 1'h0 && near(cnt[5], 24), "66 input copy");
        chk(near(cnt[1], 12) && near(cnt[0], 20), "pci from input");
        chk(near(cnt[9], 30) && o_tri_state_latched_r === 1'h1, "fixed 66 in high");
    endtask

    task automatic t_latch();
        set_mode(cos_pkg::TRI_LOW, 2'h1);
        i_select_latch_qualifier_n = 1'h0;
        i_current_multiplier_select = 1'h0;
        set_mode(cos_pkg::TRI_HIGH, 2'h2);
        win(120);
        chk(o_low_sel_latched_r === 2'h1 && o_current_multiplier_r === 1'h1, "frozen");
        chk(near(cnt[0], 30) && o_tri_state_latched_r === 1'h0, "frozen rate");
        i_select_latch_qualifier_n = 1'h1;
        i_current_multiplier_select = 1'h1;
    endtask

    task automatic t_mid();
        set_mode(cos_pkg::TRI_MID, 2'h0);
        chk(o_clk_oe_r === 1'h0, "hi-z mode");
        set_mode(cos_pkg::TRI_MID, 2'h1);
        win(120);
        chk(o_clk_oe_r === 1'h1 && near(cnt[0], 20) && near(cnt[7], 20), "test /2");
        chk(near(cnt[5], 10) && near(cnt[9], 10) && near(cnt[1], 5), "test /4 /8");
        chk(near(cnt[8], 40) && o_tri_state_latched_r === 1'h0, "test ref, mid");
    endtask

    task automatic t_stops();
        set_mode(cos_pkg::TRI_LOW, 2'h0);
        i_cfg.free_running_pci_clk_free = 3'h5;
        i_cpu_stop_n = 1'h0;
        i_pci_stop_n = 1'h0;
        waitc(20);
        win(120);
        chk(o_cpu_true_out === 3'h7 && o_cpu_complement_out === 3'h0, "cpu park");
        chk(o_pci_clk === 7'h00 && cnt[1] == 0, "pci park");
        chk(o_pci_stop_status_r === 1'h0, "pci stop status");
        chk(near(cnt[2], 15) && cnt[3] == 0 && near(cnt[4], 15), "free select");
        i_cpu_stop_n = 1'h1;
        i_pci_stop_n = 1'h1;
        i_cfg.pci_stop_bit_n = 1'h0;
        waitc(20);
        chk(o_pci_clk === 7'h00 && o_pci_stop_status_r === 1'h0, "internal stop");
        i_cfg.pci_stop_bit_n = 1'h1;
        win(60);
        chk(near(cnt[0], 10) && near(cnt[1], 8), "stops released");
    endtask

    task automatic t_pd();
        i_power_down_n = 1'h0;
        waitc(3);
        win(60);
        chk(o_clk_oe_r === 1'h0 && cnt[0] == 0 && cnt[9] == 0, "power-down");
        i_power_down_n = 1'h1;
        waitc(4);
        chk(o_clk_oe_r === 1'h1, "power-up");
    endtask

    task automatic t_sel48();
        i_cfg.sel_48 = 1'h1;
        win(120);
        chk(near(cnt[6], 24), "selectable 48");
        i_cfg.sel_48 = 1'h0;
        win(120);
        chk(near(cnt[6], 30), "selectable 66");
    endtask

    task automatic t_serial();
        i_serial_drive_low = 1'h1;
        waitc(2);
        chk(o_serial_data_line_oe === 1'h1 && o_serial_data_in_r === 1'h0, "drive low");
        i_serial_drive_low = 1'h0;
        waitc(2);
        chk(o_serial_data_line_oe === 1'h0 && o_serial_data_in_r === 1'h1, "release");
    endtask

    task automatic stop_test();
        $display("Checks %0d, failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Run needs about 1450 cycles; limit is about ten times that
    initial
    begin
        #60000;
        failures++;
        stop_test();
    end

    initial
    begin
        {cyc, failures, n_checks} = '0;
        {i_sys_rst, i_select_latch_qualifier_n, i_power_down_n} = 3'h7;
        {i_cpu_stop_n, i_pci_stop_n, i_current_multiplier_select} = 3'h7;
        {i_oscillator_input, i_shared_66mhz_in, i_serial_drive_low, clr} = 4'h0;
        i_low_freq_select = 2'h0;
        i_tri_level_freq_select = cos_pkg::TRI_LOW;
        i_tick = '0;
        i_cfg = '{1'h0, 3'h0, 1'h1};
        waitc(4);
        i_sys_rst = 1'h0;
        t_low();
        t_high();
        t_latch();
        t_mid();
        t_stops();
        t_pd();
        t_sel48();
        t_serial();
        stop_test();
    end
endmodule
